// *** design/adcsh_defs.svh ***
// Constants of the converter serial host interface: offsets, fields, counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ADCSH_DEFS_SVH
`define ADCSH_DEFS_SVH
`define ADCSH_RES_W 10
`define ADCSH_SEQ_W 16
`define ADCSH_DIN_W 8
`define ADCSH_CFG_W 8
`define ADCSH_CNT_W 6
`define ADCSH_FCNT_W 5
`define ADCSH_PCNT_W 4
`define ADCSH_OFF_ANALOG 12'h000
`define ADCSH_OFF_STATUS 12'h004
`define ADCSH_OFF_RESULT 12'h008
`define ADCSH_OFF_CONFIG 12'h00C
`define ADCSH_OFF_FRAMES 12'h010
`define ADCSH_ST_CS 0
`define ADCSH_ST_SAMPLE 1
`define ADCSH_ST_BUSY 2
`define ADCSH_ST_VALID 3
`define ADCSH_ST_OVR 4
`define ADCSH_ST_ABORT 5
`define ADCSH_DIN_WL_LO 0
`define ADCSH_DIN_WL_HI 1
`define ADCSH_DIN_ORDER 2
`define ADCSH_DIN_UNI 3
`define ADCSH_DIN_ADDR_LSB 4
`define ADCSH_DIN_ADDR_MSB 7
`define ADCSH_CONV_CYC 6'd44
`define ADCSH_SAMPLE_OPEN 5'd3
`define ADCSH_LEN_8 5'd8
`define ADCSH_LEN_10 5'd10
`define ADCSH_LEN_12 5'd12
`define ADCSH_LEN_16 5'd16
`define ADCSH_DIN_FULL 4'd8
`endif

// *** design/adcsh_pkg.sv ***
// Types of the converter serial host interface.
// Assumes the constants header is on the include path.
`include "adcsh_defs.svh"
package adcsh_pkg;
  typedef enum logic [0:0] {
    cv_idle = 1'b0,
    cv_conv = 1'b1
  } adcsh_state_t;

  typedef struct packed {
    logic cs_prev;
    logic cs_rec_n;
    logic done_prev;
    logic sample_prev;
    logic saw_done;
    adcsh_state_t state;
    logic [`ADCSH_CNT_W-1:0] cnt;
    logic [`ADCSH_RES_W-1:0] analog;
    logic [`ADCSH_RES_W-1:0] held;
    logic [`ADCSH_RES_W-1:0] result;
    logic valid;
    logic [`ADCSH_CFG_W-1:0] cfg;
    logic [`ADCSH_SEQ_W-1:0] seq;
    logic ovr;
    logic abort;
    logic [15:0] frames;
    logic [31:0] prdata;
  } adcsh_sys_t;

  typedef struct packed {
    logic [`ADCSH_FCNT_W-1:0] fcnt;
    logic done;
  } adcsh_neg_t;

  typedef struct packed {
    logic [`ADCSH_PCNT_W-1:0] pcnt;
    logic [`ADCSH_DIN_W-1:0] word;
  } adcsh_pos_t;
endpackage : adcsh_pkg

// *** design/adcsh_sync.sv ***
// Two flip-flop level synchroniser with a chosen reset value.
// Assumes d_i is asynchronous to clk_i; only q_o may be read.
`timescale 1ns/1ps
module adcsh_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [2*W-1:0] st_reg;
  logic [2*W-1:0] st_next;

  always_comb
  begin
    st_next = {st_reg[W-1:0], d_i};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= {RST, RST};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg[2*W-1:W];
endmodule : adcsh_sync

// *** design/adcsh_link.sv ***
// Shift-clock side of the serial port: input word capture, output bit
// selection, sample window and end of frame.
// Assumes select high clears the frame; seq_i is held still during a frame.
`timescale 1ns/1ps
`include "adcsh_defs.svh"
module adcsh_link (
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  input wire logic [`ADCSH_SEQ_W-1:0] seq_i,
  output logic dout_o,
  output logic sample_o,
  output logic done_o,
  output logic [`ADCSH_DIN_W-1:0] din_word_o
);
  adcsh_pkg::adcsh_neg_t neg_reg;
  adcsh_pkg::adcsh_neg_t neg_next;
  adcsh_pkg::adcsh_pos_t pos_reg;
  adcsh_pkg::adcsh_pos_t pos_next;
  logic [`ADCSH_FCNT_W-1:0] len;
  logic [`ADCSH_FCNT_W-1:0] fcnt_inc;

  // ---------------------------------------------------------------
  // Frame logic
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (pos_reg.word[`ADCSH_DIN_WL_HI:`ADCSH_DIN_WL_LO])
      2'b00: len = `ADCSH_LEN_8;
      2'b01: len = `ADCSH_LEN_10;
      2'b10: len = `ADCSH_LEN_12;
      2'b11: len = `ADCSH_LEN_16;
    endcase
    fcnt_inc = neg_reg.fcnt + 5'd1;
    neg_next = neg_reg;
    pos_next = pos_reg;
    if (!neg_reg.done)
    begin
      neg_next.fcnt = fcnt_inc;
      // The last falling edge closes the window and starts conversion.
      if (fcnt_inc == len && pos_reg.pcnt == `ADCSH_DIN_FULL)
      begin
        neg_next.done = 1'b1;
      end
    end
    // Bits beyond the input word are ignored.
    if (pos_reg.pcnt != `ADCSH_DIN_FULL)
    begin
      pos_next.pcnt = pos_reg.pcnt + 4'd1;
      pos_next.word = {pos_reg.word[`ADCSH_DIN_W-2:0], din_i};
    end
  end

  // Select high ends the frame even though the shift clock has stopped.
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      neg_reg <= '0;
    end
    else
    begin
      neg_reg <= neg_next;
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      pos_reg <= '0;
    end
    else
    begin
      pos_reg <= pos_next;
    end
  end

  // First bit is on the line before any shift clock edge.
  assign dout_o = (neg_reg.fcnt < `ADCSH_LEN_16) ? seq_i[neg_reg.fcnt[3:0]] : 1'b0;
  assign sample_o = (neg_reg.fcnt >= `ADCSH_SAMPLE_OPEN) && !neg_reg.done;
  assign done_o = neg_reg.done;
  assign din_word_o = pos_reg.word;
endmodule : adcsh_link

// *** design/adcsh_top.sv ***
// Serial host interface of a 10-bit sampling converter with an APB
// register port, select deglitching and a conversion sequencer.
// Assumes clk_sys_i is the conversion clock and sclk_i comes from the host.
//
// Operation
// - LSB-first 16-bit: fill zero or sign
// - LSB-first 16-bit gives two bytes, low first
// - Top bit is MSB or sign, first if BIT_ORDER_FLAG
// - Host selects one converter at a time
// - Sample opens 4th clock, closes last falling
// - Capacitor on plus while sampling, then minus
// - Select recognised after two conversion clock edges; the design takes four, two in the synchroniser and two in the deglitch
// - Last two input bits pick length
// - Sixth input bit sets next word order
// - Final falling edge holds input, starts conversion
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adcsh_defs.svh"
module adcsh_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic sample_phase_o,
  output logic neg_input_o,
  output logic [3:0] mux_addr_o,
  output logic conv_busy_o
);
  adcsh_pkg::adcsh_sys_t st_reg;
  adcsh_pkg::adcsh_sys_t st_next;
  logic cs_n_s;
  logic [1:0] lnk_s;
  logic lnk_sample;
  logic lnk_done;
  logic [`ADCSH_DIN_W-1:0] din_word;
  logic hit;
  logic setup;
  logic access;
  logic wr;
  logic [31:0] rd_word;
  logic [`ADCSH_SEQ_W-1:0] seq_built;

  // ---------------------------------------------------------------
  // Output word ordering
  // ---------------------------------------------------------------
  // Index 0 of the sequence is the first bit on the output line.
  function automatic logic [`ADCSH_SEQ_W-1:0] build_seq(
    input logic [`ADCSH_RES_W-1:0] res,
    input logic msb_first,
    input logic uni
  );
    logic [`ADCSH_SEQ_W-1:0] s;
    s = '0;
    for (int i = 0; i < `ADCSH_SEQ_W; i++)
    begin
      if (i < `ADCSH_RES_W)
      begin
        if (msb_first)
        begin
          s[i] = res[`ADCSH_RES_W-1-i];
        end
        else
        begin
          s[i] = res[i];
        end
      end
      else if (!msb_first && !uni)
      begin
        s[i] = res[`ADCSH_RES_W-1];
      end
      else
      begin
        s[i] = 1'b0;
      end
    end
    return s;
  endfunction : build_seq

  // ---------------------------------------------------------------
  // Link side and crossings
  // ---------------------------------------------------------------
  adcsh_link u_link (
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .seq_i(st_reg.seq),
    .dout_o(dout_o),
    .sample_o(lnk_sample),
    .done_o(lnk_done),
    .din_word_o(din_word)
  );

  adcsh_sync #(
    .W(1),
    .RST(1'b1)
  ) u_cs_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i(cs_n_i),
    .q_o(cs_n_s)
  );

  // Both levels are frame-long, so a level synchroniser is enough.
  adcsh_sync #(
    .W(2),
    .RST(2'b00)
  ) u_lnk_sync (
    .clk_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({lnk_sample, lnk_done}),
    .q_o(lnk_s)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  always_comb
  begin
    setup = psel_i && !penable_i;
    access = psel_i && penable_i;
    hit = 1'b1;
    rd_word = '0;
    unique case (paddr_i)
      `ADCSH_OFF_ANALOG:
      begin
        rd_word[`ADCSH_RES_W-1:0] = st_reg.analog;
      end
      `ADCSH_OFF_STATUS:
      begin
        rd_word[`ADCSH_ST_CS] = !st_reg.cs_rec_n;
        rd_word[`ADCSH_ST_SAMPLE] = lnk_s[1];
        rd_word[`ADCSH_ST_BUSY] = st_reg.state == adcsh_pkg::cv_conv;
        rd_word[`ADCSH_ST_VALID] = st_reg.valid;
        rd_word[`ADCSH_ST_OVR] = st_reg.ovr;
        rd_word[`ADCSH_ST_ABORT] = st_reg.abort;
      end
      `ADCSH_OFF_RESULT:
      begin
        rd_word[`ADCSH_RES_W-1:0] = st_reg.result;
      end
      `ADCSH_OFF_CONFIG:
      begin
        rd_word[`ADCSH_CFG_W-1:0] = st_reg.cfg;
      end
      `ADCSH_OFF_FRAMES:
      begin
        rd_word[15:0] = st_reg.frames;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    wr = access && pwrite_i && hit;
  end

  // ---------------------------------------------------------------
  // Deglitch, conversion sequencer and registers
  // ---------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    seq_built = build_seq(st_reg.held,
      st_reg.cfg[`ADCSH_DIN_ORDER], st_reg.cfg[`ADCSH_DIN_UNI]);
    // A new select level must be seen on two edges in a row, so a
    // pulse shorter than one conversion clock never gets through.
    st_next.cs_prev = cs_n_s;
    if (cs_n_s == st_reg.cs_prev)
    begin
      st_next.cs_rec_n = cs_n_s;
    end
    st_next.done_prev = lnk_s[0];
    st_next.sample_prev = lnk_s[1];
    if (st_reg.cs_rec_n && !st_next.cs_rec_n)
    begin
      st_next.saw_done = 1'b0;
    end
    unique case (st_reg.state)
      adcsh_pkg::cv_idle:
      begin
        if (lnk_s[0] && !st_reg.done_prev)
        begin
          st_next.held = st_reg.analog;
          st_next.cfg = din_word;
          st_next.cnt = '0;
          st_next.saw_done = 1'b1;
          st_next.frames = st_reg.frames + 16'h0001;
          st_next.state = adcsh_pkg::cv_conv;
        end
      end
      adcsh_pkg::cv_conv:
      begin
        if (st_reg.cnt == `ADCSH_CONV_CYC - 6'd1)
        begin
          st_next.result = st_reg.held;
          st_next.valid = 1'b1;
          // The order bit of this frame governs the word sent next.
          st_next.seq = seq_built;
          st_next.state = adcsh_pkg::cv_idle;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + 6'd1;
        end
      end
    endcase
    // Write one to clear. The clear comes before the set so that a new
    // event in the same cycle wins.
    if (wr && paddr_i == `ADCSH_OFF_STATUS && pstrb_i[0])
    begin
      if (pwdata_i[`ADCSH_ST_OVR])
      begin
        st_next.ovr = 1'b0;
      end
      if (pwdata_i[`ADCSH_ST_ABORT])
      begin
        st_next.abort = 1'b0;
      end
    end
    // A frame that ends mid-conversion is dropped and flagged.
    if (st_reg.state == adcsh_pkg::cv_conv && lnk_s[0] && !st_reg.done_prev)
    begin
      st_next.ovr = 1'b1;
    end
    if (!st_reg.cs_rec_n && st_next.cs_rec_n && !st_reg.saw_done
        && st_reg.sample_prev)
    begin
      st_next.abort = 1'b1;
    end
    if (wr && paddr_i == `ADCSH_OFF_ANALOG)
    begin
      if (pstrb_i[0])
      begin
        st_next.analog[7:0] = pwdata_i[7:0];
      end
      if (pstrb_i[1])
      begin
        st_next.analog[`ADCSH_RES_W-1:8] = pwdata_i[`ADCSH_RES_W-1:8];
      end
    end
    if (setup)
    begin
      st_next.prdata = rd_word;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.cs_prev <= 1'b1;
      st_reg.cs_rec_n <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata_o = st_reg.prdata;
  assign pready_o = access;
  assign pslverr_o = access && !hit;
  // Shared output line: drive only while this device is selected.
  assign dout_oe_o = !st_reg.cs_rec_n;
  assign sample_phase_o = st_reg.sample_prev;
  assign neg_input_o = st_reg.state == adcsh_pkg::cv_conv;
  assign mux_addr_o = st_reg.cfg[`ADCSH_DIN_ADDR_MSB:`ADCSH_DIN_ADDR_LSB];
  assign conv_busy_o = st_reg.state == adcsh_pkg::cv_conv;
endmodule : adcsh_top

// *** testbench/adcsh_chk.sv ***
// Checker for the converter serial port: select recognition, sample and conversion.
// Assumes it is bound to adcsh_top and sees only that module's ports.
`timescale 1ns/1ps
module adcsh_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic dout_oe_o,
  input wire logic sample_phase_o,
  input wire logic neg_input_o,
  input wire logic conv_busy_o
);
  // ----------------------------------------
  // Conversion length counter
  // ----------------------------------------
  logic [7:0] busy_cnt_reg;
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !conv_busy_o)
      busy_cnt_reg <= 8'h00;
    else
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_oe_off_high: assert property (cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) &&
    $past(cs_n_i, 3) && $past(cs_n_i, 4) |-> !dout_oe_o)
    else $error("output driven while deselected");
  a_oe_on_low: assert property (!cs_n_i && !$past(cs_n_i) && !$past(cs_n_i, 2) &&
    !$past(cs_n_i, 3) && !$past(cs_n_i, 4) |-> dout_oe_o)
    else $error("select low not recognised");
  a_oe_rise_late: assert property ($rose(dout_oe_o) |-> !$past(cs_n_i, 3) &&
    !$past(cs_n_i, 4)) else $error("output enabled before two sync edges");
  a_hold_then_neg: assert property ($fell(sample_phase_o) |-> ##[0:3] neg_input_o)
    else $error("no conversion after sample end");
  a_cap_one_side: assert property (!(sample_phase_o && neg_input_o))
    else $error("capacitor on both inputs");
  a_conv_len: assert property ($fell(conv_busy_o) |-> busy_cnt_reg == 8'h2C)
    else $error("conversion length wrong");
  a_sample_sel: assert property (sample_phase_o |-> dout_oe_o)
    else $error("sampling without select");
  a_busy_no_smp: assert property (conv_busy_o |-> !sample_phase_o)
    else $error("sampling during conversion");
endmodule : adcsh_chk
bind adcsh_top adcsh_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
  .dout_oe_o(dout_oe_o), .sample_phase_o(sample_phase_o), .neg_input_o(neg_input_o),
  .conv_busy_o(conv_busy_o));

// *** testbench/adcsh_host.sv ***
// Software-driven serial host: select, shift clock and input line, reads output.
// Assumes the caller leaves the conversion time between frames.
`timescale 1ns/1ps
module adcsh_host (
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  input wire logic sample_i
);
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  logic [15:0] rx;
  logic [15:0] smp;
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Only this host's select is lowered, as on a shared line set.
  task frame(input logic [7:0] w, input int n);
    int i;
    // Called just after a rising edge of the conversion clock.
    cs_n_o <= 1'b0;
    #150;
    for (i = 0; i < 16; i++)
    begin
      rx[i] = 1'b0;
      smp[i] = 1'b0;
      if (i < n)
      begin
        rx[i] = dout_oe_i ? dout_i : 1'bx;
        smp[i] = sample_i;
        din_o = (i < 8) ? w[7-i] : ~din_o;
        #5 sclk_o = 1'b1;
        #6 sclk_o = 1'b0;
        #1;
      end
    end
    #150 cs_n_o = 1'b1;
    // A released line must not keep showing the last bit.
    din_o = ~din_o;
  endtask : frame
  // Low across one rising edge only, shorter than one conversion clock.
  task glitch();
    #20 cs_n_o = 1'b0;
    #10 cs_n_o = 1'b1;
  endtask : glitch
endmodule : adcsh_host

// *** testbench/adcsh_tb_top.sv ***
// Testbench of the converter serial host interface: APB access and serial frames.
// Assumes the design constants header is on the include path.
`timescale 1ns/1ps
`include "adcsh_defs.svh"
module adc_serial_host_interface_tb_top;
  // ----------------------------------------
  // Signals and helpers
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cs_n, sclk, din, dout, oe, smp, neg, busy;
  logic [3:0] mux;
  int n_mismatch = 0;
  int comparisons = 0;
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  adcsh_top DUT (.clk_sys_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .sclk_i(sclk),
    .cs_n_i(cs_n), .din_i(din), .dout_o(dout), .dout_oe_o(oe), .sample_phase_o(smp),
    .neg_input_o(neg), .mux_addr_o(mux), .conv_busy_o(busy));
  adcsh_host host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout),
    .dout_oe_i(oe), .sample_i(smp));
  task finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      n_mismatch++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Bit i of the result is the i-th bit shifted out.
  function automatic logic [15:0] expo(input logic [9:0] r, input logic m, input logic u,
                                       input int n);
    logic [15:0] v;
    int i;
    v = 16'h0000;
    for (i = 0; i < n; i++)
      v[i] = m ? (i < 10 ? r[9-i] : 1'b0) : (i < 10 ? r[i] : (u ? 1'b0 : r[9]));
    return v;
  endfunction : expo
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  logic [7:0] wd [6] = '{8'h8B, 8'hDF, 8'hED, 8'h32, 8'h53, 8'h94};
  logic [9:0] an [6] = '{10'h2B5, 10'h1C3, 10'h3F0, 10'h2AA, 10'h155, 10'h000};
  int ln [4] = '{8, 10, 12, 16};
  logic [31:0] rd;
  logic er;
  logic [9:0] pres = 10'h000;
  logic pord = 1'b0;
  logic puni = 1'b0;
  logic seen_oe;
  int n;
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    host.glitch();
    seen_oe = 1'b0;
    repeat (6)
    begin
      @(negedge clk);
      seen_oe = seen_oe | oe;
    end
    chk("oe after glitch", {31'h0, seen_oe}, 32'h0);
    $display("test glitch done");
    for (int k = 0; k < 6; k++)
    begin
      n = ln[wd[k][1:0]];
      apb(1'b1, `ADCSH_OFF_ANALOG, {22'h0, an[k]}, rd, er);
      apb(1'b0, `ADCSH_OFF_ANALOG, 32'h0, rd, er);
      chk("analog", rd, {22'h0, an[k]});
      host.frame(wd[k], n);
      chk("dout", {16'h0, host.rx}, {16'h0, expo(pres, pord, puni, n)});
      chk("early sample", {29'h0, host.smp[2:0]}, 32'h0);
      if (n == 16)
        chk("late sample", {31'h0, host.smp[15]}, 32'h1);
      chk("busy", {31'h0, busy}, 32'h1);
      chk("neg input", {31'h0, neg}, 32'h1);
      repeat (50) @(posedge clk);
      apb(1'b0, `ADCSH_OFF_RESULT, 32'h0, rd, er);
      chk("result", rd, {22'h0, an[k]});
      apb(1'b0, `ADCSH_OFF_STATUS, 32'h0, rd, er);
      chk("status", rd, 32'h00000008);
      apb(1'b0, `ADCSH_OFF_CONFIG, 32'h0, rd, er);
      chk("config", rd, {24'h0, wd[k]});
      apb(1'b0, `ADCSH_OFF_FRAMES, 32'h0, rd, er);
      chk("frames", rd, 32'(k + 1));
      chk("mux", {28'h0, mux}, {28'h0, wd[k][7:4]});
      pres = an[k];
      pord = wd[k][`ADCSH_DIN_ORDER];
      puni = wd[k][`ADCSH_DIN_UNI];
      $display("test frame %0d done", k);
    end
    apb(1'b0, 12'h0FC, 32'h0, rd, er);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test unmapped done");
    finish_test();
  end
endmodule : adc_serial_host_interface_tb_top
